// ==== design/trc_pkg.sv ====
package trc_pkg;
  localparam int NCH = 8;
  localparam int CHW = 3;
  localparam int NBLK = 2;
  localparam int SBW = 17;
  localparam int STW = NBLK * SBW;
  localparam int OC_BIT = 16;
  localparam int FRAME_W = 24;
  localparam int F_RW = 23;
  localparam int F_PORT = 21;
  localparam int F_CHAN = 12;
  localparam int F_SEL = 9;
  localparam int DATA_W = 9;
  localparam int BITC_W = 5;
  localparam int DIV_W = 3;
  localparam int CLK_NS = 10;
  localparam int BIT_NS = 40;
  localparam int DIV_CYC = (BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] MODE_ANALOG = 3'h0;
  localparam logic [2:0] MODE_RATEDIV = 3'h3;
  localparam logic [2:0] MODE_TXPLL = 3'h4;
  localparam logic [2:0] MODE_CHPLL = 3'h5;
  localparam logic [2:0] MODE_CHSEL = 3'h6;
  localparam logic [2:0] MODE_CLKSEL = 3'h7;
  localparam logic [1:0] PORT_BOTH = 2'h0;
  localparam logic [1:0] PORT_RX = 2'h1;
  localparam logic [1:0] PORT_TX = 2'h2;
  localparam logic [1:0] PORT_BAD = 2'h3;
  localparam logic [2:0] SEL_SWING = 3'h0;
  localparam logic [2:0] SEL_PRE = 3'h1;
  localparam logic [2:0] SEL_POST = 3'h2;
  localparam logic [2:0] SEL_WORD = 3'h3;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_IDX = 8'h08;
  localparam logic [7:0] ADDR_ERRS = 8'h0c;
  localparam int CFG_CONT = 0;
  localparam int CFG_LAT = 4;
  localparam int LAT_W = 4;
  localparam int CFG_CNT = 8;
  localparam int CNT_W = 8;
  localparam logic [31:0] CFG_RESET = 32'h0000_1011;
  localparam int STB_BUSY = 0;
  localparam int STB_ERR = 1;
  localparam int STB_OC = 2;
  localparam int STB_DV = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] ERR_LAST = 2'h1;

  typedef enum logic [2:0] {
    ST_START = 3'h0, ST_OFFSET = 3'h1, ST_IDLE = 3'h2, ST_ANA = 3'h3,
    ST_FETCH = 3'h4, ST_SEND = 3'h5, ST_ERR = 3'h6, ST_RDONE = 3'h7
  } trc_state_e;

  // Code minus 16 in five bits, with code 0 also meaning zero
  function automatic logic [4:0] preDecode(input logic [4:0] code);
    return (code == 5'h00) ? 5'h00 : code - 5'h10;
  endfunction

  function automatic logic [FRAME_W-1:0] mkFrame(input logic rw, input logic [1:0] port,
      input logic [8:0] chan, input logic [2:0] sel, input logic [DATA_W-1:0] data);
    return {rw, port, chan, sel, data};
  endfunction
endpackage

// ==== design/trc_if.sv ====
`timescale 1ns/1ns
interface trc_ser_if import trc_pkg::*; ();
  logic               start;
  logic [FRAME_W-1:0] frame;
  logic               done;
  logic               active;
  logic [3:0]         line;
  modport ctrl(output start, frame, input done, active, line);
  modport ser(input start, frame, output done, active, line);
endinterface

interface trc_reg_if import trc_pkg::*; ();
  logic              wrEn;
  logic [ADDR_W-1:0] wrAddr;
  logic [31:0]       wrData;
  logic [3:0]        wrStrb;
  logic [ADDR_W-1:0] rdAddr;
  logic [31:0]       rdData;
  logic              wrHit;
  logic              rdHit;
  modport bus(output wrEn, wrAddr, wrData, wrStrb, rdAddr, input rdData, wrHit, rdHit);
  modport regs(input wrEn, wrAddr, wrData, wrStrb, rdAddr, output rdData, wrHit, rdHit);
endinterface

// ==== design/trc_serial.sv ====
`timescale 1ns/1ns
module trc_serial import trc_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  trc_ser_if.ser   sif
);
  logic [FRAME_W-1:0] shiftReg;
  logic [BITC_W-1:0]  bitCnt;
  logic [DIV_W-1:0]   divCnt;
  logic               rwQ;
  logic               running;
  logic               tick;

  assign tick = running && (divCnt == DIV_W'(DIV_CYC - 1));
  assign sif.active = running;

  // Frame goes out msb first, one bit per divider tick
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shiftReg <= '0;
      bitCnt <= '0;
      divCnt <= '0;
      rwQ <= 1'b0;
      running <= 1'b0;
      sif.done <= 1'b0;
      sif.line <= 4'h0;
    end else begin
      sif.done <= 1'b0;
      if (!running) begin
        sif.line <= 4'h0;
        if (sif.start) begin
          shiftReg <= sif.frame;
          rwQ <= sif.frame[F_RW];
          running <= 1'b1;
          bitCnt <= '0;
          divCnt <= '0;
        end
      end else begin
        divCnt <= tick ? '0 : divCnt + 1'b1;
        sif.line <= {rwQ, tick, shiftReg[FRAME_W-1], 1'b1};
        if (tick) begin
          shiftReg <= shiftReg << 1;
          bitCnt <= bitCnt + 1'b1;
          if (bitCnt == BITC_W'(FRAME_W - 1)) begin
            running <= 1'b0;
            sif.done <= 1'b1;
          end
        end
      end
    end
  end
endmodule // trc_serial

// ==== design/trc_axil.sv ====
`timescale 1ns/1ns
module trc_axil import trc_pkg::*; (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              awvalid,
  output      logic              awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              wvalid,
  output      logic              wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output      logic              bvalid,
  input  wire logic              bready,
  output      logic [1:0]        bresp,
  input  wire logic              arvalid,
  output      logic              arready,
  input  wire logic [ADDR_W-1:0] araddr,
  output      logic              rvalid,
  input  wire logic              rready,
  output      logic [31:0]       rdata,
  output      logic [1:0]        rresp,
  trc_reg_if.bus                 rif
);
  logic awHave;
  logic wHave;

  assign awready = !awHave;
  assign wready = !wHave;
  assign arready = !rvalid;
  assign rif.rdAddr = araddr;
  assign rif.wrEn = awHave && wHave && !bvalid;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awHave <= 1'b0;
      wHave <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
      rif.wrAddr <= '0;
      rif.wrData <= '0;
      rif.wrStrb <= '0;
    end else begin
      if (awvalid && awready) begin
        awHave <= 1'b1;
        rif.wrAddr <= awaddr;
      end
      if (wvalid && wready) begin
        wHave <= 1'b1;
        rif.wrData <= wdata;
        rif.wrStrb <= wstrb;
      end
      if (rif.wrEn) begin
        awHave <= 1'b0;
        wHave <= 1'b0;
        bvalid <= 1'b1;
        bresp <= rif.wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rif.rdData;
        rresp <= rif.rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule // trc_axil

// ==== design/trc_ctrl.sv ====
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
module trc_ctrl import trc_pkg::*; (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              awvalid,
  output      logic              awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              wvalid,
  output      logic              wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output      logic              bvalid,
  input  wire logic              bready,
  output      logic [1:0]        bresp,
  input  wire logic              arvalid,
  output      logic              arready,
  input  wire logic [ADDR_W-1:0] araddr,
  output      logic              rvalid,
  input  wire logic              rready,
  output      logic [31:0]       rdata,
  output      logic [1:0]        rresp,
  input  wire logic              writeAll,
  input  wire logic              readReq,
  input  wire logic [2:0]        modeSel,
  input  wire logic [CHW-1:0]    channelAddr,
  input  wire logic [1:0]        duplexSel,
  input  wire logic [2:0]        swingSetting,
  input  wire logic [4:0]        pretap_emphasis_setting,
  input  wire logic [4:0]        first_posttap_setting,
  output      logic [CNT_W-1:0]  mifAddr,
  input  wire logic [DATA_W-1:0] mifData,
  output      logic              busy,
  output      logic              dataValid,
  output      logic              error,
  output      logic [2:0]        swingOut,
  output      logic [4:0]        pretapOut,
  output      logic [4:0]        posttapOut,
  input  wire logic [STW-1:0]    statusBus,
  output      logic [3:0]        controlBus
);
  trc_state_e        state;
  trc_state_e        next_state;
  logic [STW-1:0]    statusMeta;
  logic [STW-1:0]    statusSync;
  logic              ocDone;
  logic [31:0]       cfgReg;
  logic [31:0]       statWord;
  logic              contMode;
  logic [LAT_W-1:0]  latency;
  logic [CNT_W-1:0]  wordCnt;
  logic [CHW-1:0]    chanL;
  logic [1:0]        portL;
  logic [2:0]        modeL;
  logic              isRead;
  logic              contL;
  logic [2:0]        swingL;
  logic [4:0]        preL;
  logic [4:0]        postL;
  logic [2:0]        swingMem [NCH];
  logic [4:0]        preMem [NCH];
  logic [4:0]        postMem [NCH];
  logic [1:0]        step;
  logic              lastStep;
  logic [LAT_W-1:0]  latCnt;
  logic [CNT_W-1:0]  wordIdx;
  logic [CNT_W-1:0]  idxNext;
  logic              lastWord;
  logic [DATA_W-1:0] wordL;
  logic [1:0]        errCnt;
  logic [7:0]        errTotal;
  logic              accWr;
  logic              accRd;
  logic              badWr;
  logic              badRd;
  logic              modeKnown;
  logic              rdModeOk;
  logic              serStart;
  logic [2:0]        stepSel;
  logic [DATA_W-1:0] stepData;
  logic [FRAME_W-1:0] anaFrame;
  logic [FRAME_W-1:0] wordFrame;

  trc_ser_if sif();
  trc_reg_if rif();

  trc_axil uAxil (
    .ref_clk (ref_clk),
    .rst     (rst),
    .awvalid (awvalid),
    .awready (awready),
    .awaddr  (awaddr),
    .wvalid  (wvalid),
    .wready  (wready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .bvalid  (bvalid),
    .bready  (bready),
    .bresp   (bresp),
    .arvalid (arvalid),
    .arready (arready),
    .araddr  (araddr),
    .rvalid  (rvalid),
    .rready  (rready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rif     (rif.bus)
  );

  trc_serial uSer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .sif     (sif.ser)
  );

  // Status bus comes from the transceiver side, so it is synchronised first
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      statusMeta <= '0;
      statusSync <= '0;
    end else begin
      statusMeta <= statusBus;
      statusSync <= statusMeta;
    end
  end

  // One 17-bit slice per block, lowest block at bit 0
  function automatic logic allDone(input logic [STW-1:0] s);
    logic ok;
    ok = 1'b1;
    for (int b = 0; b < NBLK; b++) begin
      ok = ok & s[b * SBW + OC_BIT];
    end
    return ok;
  endfunction

  assign ocDone = allDone(statusSync);
  assign contMode = cfgReg[CFG_CONT];
  assign latency = cfgReg[CFG_LAT +: LAT_W];
  assign wordCnt = cfgReg[CFG_CNT +: CNT_W];
  assign modeKnown = modeSel inside {MODE_ANALOG, MODE_RATEDIV, MODE_TXPLL,
                                     MODE_CHPLL, MODE_CHSEL, MODE_CLKSEL};
  assign rdModeOk = modeSel == MODE_ANALOG || modeSel == MODE_RATEDIV;
  assign badWr = !modeKnown || duplexSel == PORT_BAD
               || (modeSel != MODE_ANALOG && wordCnt == '0);
  assign badRd = !rdModeOk || duplexSel == PORT_BAD;
  assign accWr = writeAll && state == ST_IDLE;
  assign accRd = readReq && !writeAll && state == ST_IDLE;
  assign lastStep = isRead || step == 2'h2;
  assign idxNext = wordIdx + 1'b1;
  assign lastWord = idxNext >= wordCnt;
  assign mifAddr = wordIdx;
  assign controlBus = sif.line;
  assign sif.start = serStart;
  assign sif.frame = (state == ST_SEND) ? wordFrame : anaFrame;
  assign anaFrame = mkFrame(isRead, portL, 9'(chanL), stepSel, stepData);
  assign wordFrame = mkFrame(1'b0, portL, 9'(chanL), SEL_WORD, wordL);

  // Analog write sends swing, then pre-tap, then first post-tap
  always_comb begin
    stepSel = SEL_SWING;
    stepData = DATA_W'(swingL);
    if (!isRead) begin
      case (step)
        2'h1: begin
          stepSel = SEL_PRE;
          stepData = DATA_W'(preDecode(preL));
        end
        2'h2: begin
          stepSel = SEL_POST;
          stepData = DATA_W'(preDecode(postL));
        end
        default: begin
          stepSel = SEL_SWING;
          stepData = DATA_W'(swingL);
        end
      endcase
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_START: next_state = ST_OFFSET;
      ST_OFFSET: if (ocDone) next_state = ST_IDLE;
      ST_IDLE: begin
        if (accWr) begin
          if (badWr) next_state = ST_ERR;
          else if (modeSel == MODE_ANALOG) next_state = ST_ANA;
          else next_state = ST_FETCH;
        end else if (accRd) begin
          next_state = badRd ? ST_ERR : ST_ANA;
        end
      end
      ST_ANA: begin
        if (sif.done && lastStep) begin
          next_state = (isRead && modeL == MODE_ANALOG) ? ST_RDONE : ST_IDLE;
        end
      end
      ST_FETCH: if (latCnt == '0) next_state = ST_SEND;
      ST_SEND: begin
        if (sif.done) next_state = (contL && !lastWord) ? ST_FETCH : ST_IDLE;
      end
      ST_RDONE: next_state = ST_IDLE;
      ST_ERR: if (errCnt == ERR_LAST) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_START;
      busy <= 1'b0;
      error <= 1'b0;
      dataValid <= 1'b0;
    end else begin
      state <= next_state;
      busy <= next_state inside {ST_OFFSET, ST_ANA, ST_FETCH, ST_SEND};
      error <= next_state == ST_ERR;
      dataValid <= next_state == ST_RDONE;
    end
  end

  // Request inputs are captured only with an accepted pulse
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      chanL <= '0;
      portL <= PORT_BOTH;
      modeL <= MODE_ANALOG;
      isRead <= 1'b0;
      contL <= 1'b0;
      swingL <= '0;
      preL <= '0;
      postL <= '0;
    end else if (accWr || accRd) begin
      chanL <= channelAddr;
      portL <= duplexSel;
      modeL <= modeSel;
      isRead <= !accWr;
      contL <= contMode;
      swingL <= swingSetting;
      preL <= pretap_emphasis_setting;
      postL <= first_posttap_setting;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) begin
        swingMem[i] <= '0;
        preMem[i] <= '0;
        postMem[i] <= '0;
      end
    end else if (accWr && !badWr && modeSel == MODE_ANALOG) begin
      swingMem[channelAddr] <= swingSetting;
      preMem[channelAddr] <= pretap_emphasis_setting;
      postMem[channelAddr] <= first_posttap_setting;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      swingOut <= '0;
      pretapOut <= '0;
      posttapOut <= '0;
    end else if (next_state == ST_RDONE) begin
      swingOut <= swingMem[chanL];
      pretapOut <= preMem[chanL];
      posttapOut <= postMem[chanL];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      serStart <= 1'b0;
      step <= '0;
      latCnt <= '0;
      wordIdx <= '0;
      wordL <= '0;
    end else begin
      serStart <= 1'b0;
      if (state == ST_IDLE && next_state == ST_ANA) begin
        step <= '0;
        serStart <= 1'b1;
      end else if (state == ST_ANA && sif.done && !lastStep) begin
        step <= step + 1'b1;
        serStart <= 1'b1;
      end
      if (next_state == ST_FETCH && state != ST_FETCH) begin
        latCnt <= latency;
        if (state == ST_IDLE && contMode) wordIdx <= '0;
      end else if (state == ST_FETCH && latCnt != '0) begin
        latCnt <= latCnt - 1'b1;
      end
      if (state == ST_FETCH && latCnt == '0) begin
        wordL <= mifData;
        serStart <= 1'b1;
      end
      if (state == ST_SEND && sif.done) begin
        wordIdx <= lastWord ? '0 : idxNext;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      errCnt <= '0;
      errTotal <= '0;
    end else begin
      errCnt <= (state == ST_ERR) ? errCnt + 1'b1 : '0;
      if (state != ST_ERR && next_state == ST_ERR) errTotal <= errTotal + 1'b1;
    end
  end

  // Configuration register with byte strobes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfgReg <= CFG_RESET;
    end else if (rif.wrEn && rif.wrHit) begin
      for (int b = 0; b < 4; b++) begin
        if (rif.wrStrb[b]) cfgReg[b * 8 +: 8] <= rif.wrData[b * 8 +: 8];
      end
    end
  end

  always_comb begin
    statWord = '0;
    statWord[STB_BUSY] = busy;
    statWord[STB_ERR] = error;
    statWord[STB_OC] = ocDone;
    statWord[STB_DV] = dataValid;
  end

  assign rif.wrHit = rif.wrAddr == ADDR_CFG;
  assign rif.rdHit = rif.rdAddr inside {ADDR_CFG, ADDR_STAT, ADDR_IDX, ADDR_ERRS};

  always_comb begin
    case (rif.rdAddr)
      ADDR_CFG: rif.rdData = cfgReg;
      ADDR_STAT: rif.rdData = statWord;
      ADDR_IDX: rif.rdData = 32'(wordIdx);
      ADDR_ERRS: rif.rdData = 32'(errTotal);
      default: rif.rdData = '0;
    endcase
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_first_cycle_low: assert property (
    state == ST_START |-> !busy ##1 busy)
    else $error("busy not low then high after reset");

  a_offset_busy: assert property (
    state == ST_OFFSET && !ocDone |=> busy && state == ST_OFFSET)
    else $error("busy dropped before offset cancellation done");

  a_analog_busy: assert property (
    state == ST_ANA |-> busy && !error)
    else $error("busy low during analog transaction");

  a_word_busy: assert property (
    state inside {ST_FETCH, ST_SEND} |-> busy)
    else $error("busy low during file word write");

  a_error_window: assert property (
    $rose(error) |-> (error && !busy) [*2] ##1 !error)
    else $error("error not exactly two cycles with busy low");

  a_bad_read: assert property (
    accRd && !rdModeOk |=> error && !busy)
    else $error("read in wrong mode not flagged");

  a_ignore_busy: assert property (
    busy && (writeAll || readReq) |=> $stable(chanL) && $stable(modeL))
    else $error("request taken while busy");

  a_valid_mode: assert property (
    dataValid |-> modeL == MODE_ANALOG && isRead && !busy)
    else $error("dataValid outside analog read");

  a_readback_value: assert property (
    dataValid |-> pretapOut == preMem[chanL] && posttapOut == postMem[chanL])
    else $error("read-back differs from stored setting");

  a_pretap_frame: assert property (
    state == ST_ANA && serStart && !isRead && step == 2'h1
    |-> sif.frame[DATA_W-1:0] == DATA_W'(preDecode(preL)) && sif.frame[F_SEL +: 3] == SEL_PRE)
    else $error("pre-tap frame carries wrong value");

  a_portion_frame: assert property (
    serStart |-> sif.frame[F_PORT +: 2] == portL && portL != PORT_BAD)
    else $error("frame portion differs from request");

  a_continuous_next: assert property (
    state == ST_SEND && sif.done && contL && !lastWord |=> state == ST_FETCH ##1 busy)
    else $error("continuous write stopped early");
endmodule // trc_ctrl

// ==== tb/trc_xcvr_model.sv ====
`timescale 1ns/1ns
module trc_xcvr_model import trc_pkg::*; (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [3:0]        controlBus,
  input  wire logic [CNT_W-1:0]  mifAddr,
  output      logic [STW-1:0]    statusBus,
  output      logic [DATA_W-1:0] mifData,
  output      logic [FRAME_W-1:0] lastFrame,
  output      logic [7:0]        frameCount
);
  logic [5:0]         ocCount;
  logic [FRAME_W-1:0] rxShift;
  logic [BITC_W-1:0]  rxBits;
  // Frames are rebuilt msb first from the data bit at each strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxShift <= '0;
      rxBits <= '0;
      lastFrame <= '0;
      frameCount <= '0;
    end else if (controlBus[2]) begin
      rxShift <= {rxShift[FRAME_W-2:0], controlBus[1]};
      rxBits <= (rxBits == BITC_W'(FRAME_W - 1)) ? '0 : rxBits + 1'b1;
      if (rxBits == BITC_W'(FRAME_W - 1)) begin
        lastFrame <= {rxShift[FRAME_W-2:0], controlBus[1]};
        frameCount <= frameCount + 1'b1;
      end
    end
  end
  // Offset cancellation ends some cycles after reset; one 17-bit slice per block
  always_ff @(posedge ref_clk) begin
    ocCount <= rst ? 6'h00 : ocCount + {5'h00, ~&ocCount};
    mifData <= {1'b1, mifAddr};
  end
  assign statusBus = {&ocCount, 16'h0000, &ocCount, 16'h0000};
endmodule // trc_xcvr_model

// ==== tb/trc_ctrl_tb.sv ====
`timescale 1ns/1ns
module trc_ctrl_tb import trc_pkg::*; ;
  logic ref_clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic writeAll = 0, readReq = 0, busy, dataValid, error, awready, wready, bvalid;
  logic arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'hf, controlBus;
  logic [1:0] bresp, rresp, duplexSel = 2'h0;
  logic [2:0] modeSel = 3'h0, channelAddr = 3'h0, swingSetting = 3'h0, swingOut;
  logic [4:0] pretap_emphasis_setting = 5'h00, first_posttap_setting = 5'h00;
  logic [4:0] pretapOut, posttapOut;
  logic [CNT_W-1:0] mifAddr;
  logic [DATA_W-1:0] mifData;
  logic [STW-1:0] statusBus;
  int errCount = 0, cmpCount = 0, i;
  logic [FRAME_W-1:0] lastFrame;
  logic [7:0] frameCount;
  always #5 ref_clk = ~ref_clk;
  trc_ctrl uut (.*);
  trc_xcvr_model xm (.*);
  task summarize;
    $display("checks %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmpCount++;
    if (s !== e) begin
      errCount++;
      $display("FAIL %s exp %h got %h", nm, e, s);
    end
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge ref_clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    bready <= 0;
    chk("bvalid", bvalid, 1);
    chk("bresp", bresp, er);
  endtask
  task axr(input logic [7:0] a, input logic [1:0] er);
    araddr <= a; arvalid <= 1; rready <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge ref_clk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    rready <= 0; rd = rdata;
    chk("rvalid", rvalid, 1);
    chk("rresp", rresp, er);
  endtask
  task waitIdle;
    for (i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge ref_clk);
    chk("idle", busy, 0);
  endtask
  task pulse(input logic w, input logic [2:0] m, input logic [1:0] d);
    @(posedge ref_clk);
    writeAll <= w;
    readReq <= ~w;
    modeSel <= m;
    duplexSel <= d;
    @(posedge ref_clk);
    writeAll <= 0;
    readReq <= 0;
    #1;
  endtask
  task rdBack(input logic [2:0] ch, input logic [2:0] sw, input logic [4:0] pr, po);
    @(posedge ref_clk);
    channelAddr <= ch;
    pulse(0, MODE_ANALOG, PORT_BOTH);
    for (i = 0; i < 2000 && dataValid !== 1'b1; i++) @(posedge ref_clk) #1;
    chk("valid", dataValid, 1);
    chk("busyAtValid", busy, 0);
    chk("swing", swingOut, sw);
    chk("pretap", pretapOut, pr);
    chk("posttap", posttapOut, po);
    chk("rdFrame", lastFrame[FRAME_W-1:F_CHAN], {1'b1, PORT_BOTH, 9'(ch)});
    @(posedge ref_clk) #1 chk("validPulse", dataValid, 0);
  endtask
  task testReset;
    repeat (2) @(posedge ref_clk);
    rst <= 0;
    #1 chk("busyFirst", busy, 0);
    @(posedge ref_clk) #1 chk("busyOc", busy, 1);
    waitIdle();
    chk("ocDone", busy, 0);
    $display("test reset done");
  endtask
  task testRegs;
    axr(ADDR_CFG, RESP_OKAY);
    chk("cfgReset", rd, CFG_RESET);
    axw(ADDR_CFG, 32'h0000_1021, RESP_OKAY);
    axr(ADDR_CFG, RESP_OKAY);
    chk("cfgWrite", rd, 32'h0000_1021);
    axw(8'h10, 32'h0, RESP_SLVERR);
    axr(8'h10, RESP_SLVERR);
    $display("test registers done");
  endtask
  task testAnalog;
    int f0;
    @(posedge ref_clk);
    channelAddr <= 3'h2;
    swingSetting <= 3'h7;
    pretap_emphasis_setting <= 5'h11;
    first_posttap_setting <= 5'h0f;
    f0 = frameCount;
    pulse(1, MODE_ANALOG, PORT_TX);
    chk("busyWrite", busy, 1);
    @(posedge ref_clk);
    swingSetting <= 3'h0;
    pulse(1, MODE_ANALOG, PORT_TX);
    waitIdle();
    chk("anaFrames", frameCount - f0, 3);
    chk("postFrame", lastFrame, {1'b0, PORT_TX, 9'h002, SEL_POST, 9'h01f});
    rdBack(3'h2, 3'h7, 5'h11, 5'h0f);
    rdBack(3'h5, 3'h0, 5'h00, 5'h00);
    $display("test analog done");
  endtask
  task testErrors;
    for (int k = 0; k < 4; k++) begin
      pulse(k != 3, k == 2 ? MODE_ANALOG : 3'(k + 1), k == 2 ? PORT_BAD : PORT_BOTH);
      chk("errOn", {error, busy}, 2'b10);
      @(posedge ref_clk) #1 chk("errTwo", error, 1);
      @(posedge ref_clk) #1 chk("errOff", error, 0);
    end
    @(posedge ref_clk);
    axr(ADDR_ERRS, RESP_OKAY);
    chk("errCountReg", rd, 4);
    $display("test error done");
  endtask
  task testFile;
    int f0;
    @(posedge ref_clk);
    channelAddr <= 3'h6;
    f0 = frameCount;
    pulse(1, MODE_TXPLL, PORT_BOTH);
    waitIdle();
    chk("contFrames", frameCount - f0, 16);
    chk("contLast", lastFrame, {1'b0, PORT_BOTH, 9'h006, SEL_WORD, 9'h10f});
    chk("contIdx", mifAddr, 0);
    axw(ADDR_CFG, 32'h0000_0220, RESP_OKAY);
    for (int n = 0; n < 2; n++) begin
      pulse(1, MODE_TXPLL, PORT_BOTH);
      waitIdle();
      chk("wordData", lastFrame[DATA_W-1:0], 9'h100 + n);
      chk("wordIdx", mifAddr, (n + 1) % 2);
    end
    @(posedge ref_clk);
    pretap_emphasis_setting <= 5'h00;
    pulse(1, MODE_RATEDIV, PORT_TX);
    waitIdle();
    chk("rateWrite", lastFrame[FRAME_W-1:F_PORT], {1'b0, PORT_TX});
    f0 = frameCount;
    pulse(0, MODE_RATEDIV, PORT_RX);
    waitIdle();
    chk("rateNoValid", dataValid, 0);
    chk("rateRead", lastFrame[FRAME_W-1:F_PORT], {1'b1, PORT_RX});
    chk("rateFrames", frameCount - f0, 1);
    chk("rateNoErr", error, 0);
    $display("test file done");
  endtask
  initial begin
    testReset();
    testRegs();
    testAnalog();
    testErrors();
    testFile();
    summarize();
  end
  initial begin
    #200000;
    errCount++;
    summarize();
  end
endmodule // trc_ctrl_tb
